// >>> src/srq_pkg.sv
// Constants for the status reporting and service request block.
// Assumes one system clock; bit positions follow the status byte layout.
package srq_pkg;
   // ==========================================
   // Event latch bit positions
   localparam int unsigned EV_OP_DONE = 0;
   localparam int unsigned EV_UNUSED_A = 1;
   localparam int unsigned EV_QUERY_ERR = 2;
   localparam int unsigned EV_DEVICE_ERR = 3;
   localparam int unsigned EV_BAD_PARAM = 4;
   localparam int unsigned EV_PARSE_ERR = 5;
   localparam int unsigned EV_UNUSED_B = 6;
   localparam int unsigned EV_POWER_CYCLED = 7;
   // ==========================================
   // Status byte bit positions
   localparam int unsigned SB_MSG_WAITING = 4;
   localparam int unsigned SB_EVENT_SUMMARY = 5;
   localparam int unsigned SB_SERVICE = 6;
   // ==========================================
   // Masks and reset values
   localparam logic [7:0] EVENT_USED_MASK = 8'hbd;
   localparam logic [7:0] SRQ_GATED_MASK = 8'hbe;
   localparam logic [7:0] EVENT_LATCH_RESET = 8'h80;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [15:0] EVENT_MASK_MAX = 16'h00ff;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage : srq_pkg

// >>> src/event_latch_if.sv
// Interface between the status logic and the event latch register.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
interface event_latch_if;
   logic [7:0] setVec;
   logic clear;
   // A net, since each latch bit drives its own slice from a generate branch
   wire logic [7:0] value;
   modport latch (input setVec, input clear, output value);
   modport user (output setVec, output clear, input value);
endinterface : event_latch_if
`default_nettype wire

// >>> src/event_latch.sv
// Sticky event latch register, one flag per used event bit.
// Assumes single-cycle event pulses and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module event_latch
   import srq_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // Latch access
   event_latch_if.latch evt
);
   // ==========================================
   // Per-bit sticky flags
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_bit
         if (EVENT_USED_MASK[i]) begin : g_used
            logic flag_ff;
            // Set beats clear so an event in the clearing cycle survives
            wire logic nxt_flag = evt.setVec[i] | (flag_ff & ~evt.clear);
            always_ff @(posedge clk) begin
               if (!rst_b) begin
                  flag_ff <= EVENT_LATCH_RESET[i];
               end else if (ce) begin
                  flag_ff <= nxt_flag;
               end
            end
            assign evt.value[i] = flag_ff;
         end else begin : g_unused
            assign evt.value[i] = 1'b0;
         end
      end
   endgenerate
endmodule // event_latch
`default_nettype wire

// >>> src/status_reporting_service_request.sv
// Status byte, event summary and service request logic of an instrument.
// Assumes a command parser that delivers one-cycle pulses on clk.
//
// What this block does
// - Event latch bits stay set until the latch is read or cleared.
// - Event mask bit enables its latch bit toward the summary.
// - Any enabled latch bit rising sets the event summary bit.
// - Latch read or clear-status returns the event summary bit to zero.
// - Operation done flag set when all commands before it are executed.
// - Latch bits 1 and 6 always read zero.
// - Query error flag set on any of the three query faults.
// - Device-specific error flag set on calibration fault or port overflow.
// - Bad parameter flag set when a command cannot execute.
// - Command parse flag set when a command was not understood.
// - Power cycled flag set after power returns until latch read or clear-status.
// - Message waiting set on queued response, cleared after terminator sent.
// - Service mask gates status bits 1-5 and 7 into bit 6.
// - Master summary follows enabled status bits continuously.
// - Request bit set by summary rising or panel; serial poll clears it.
// - Service request line asserted while request bit is set.
// - Status query returns the byte without changing any bit.
// - Bit 6 is request bit on poll, master summary on query.
// - Remote unlocked panel press can raise a service request.
// - Power-up and device clear zero the service request mask.
// - Clear-status clears events; message waiting only when first message.
// - Event mask writes above 255 rejected, setting bad parameter flag.
`timescale 1ns/1ps
`default_nettype none
module status_reporting_service_request
   import srq_pkg::*;
(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   // Event pulses from the parser
   input wire logic opDone,
   input wire logic queryFault,
   input wire logic deviceFault,
   input wire logic badParam,
   input wire logic parseFault,
   // Register commands
   input wire logic latchRead,
   input wire logic clearStatus,
   input wire logic clearIsFirst,
   input wire logic eventMaskWrite,
   input wire logic [15:0] eventMaskValue,
   input wire logic serviceMaskWrite,
   input wire logic [7:0] serviceMaskValue,
   input wire logic deviceClear,
   input wire logic statusQuery,
   input wire logic serialPoll,
   // Output buffer and front panel
   input wire logic responseQueued,
   input wire logic terminatorSent,
   input wire logic panelRequest,
   input wire logic remoteUnlocked,
   // Read data
   output logic [7:0] latchData,
   output logic [7:0] eventMaskData,
   output logic [7:0] serviceMaskData,
   output logic [7:0] statusQueryData,
   output logic [7:0] pollData,
   // Service request line, open drain
   output logic srqOut,
   output logic srqEn_b
);
   // ==========================================
   // State
   logic [7:0] eventMask_ff;
   logic [7:0] serviceMask_ff;
   logic eventSummary_ff;
   logic msgWaiting_ff;
   logic serviceReq_ff;
   logic masterPrev_ff;
   logic [7:0] latchData_ff;
   logic [7:0] statusQueryData_ff;
   logic [7:0] pollData_ff;
   logic [7:0] prevLatch_ff;

   event_latch_if evt ();

   // ==========================================
   // Event inputs into the latch
   wire logic maskTooBig = eventMaskWrite & (eventMaskValue > EVENT_MASK_MAX);
   wire logic maskAccept = eventMaskWrite & ~maskTooBig;
   wire logic [7:0] eventSet = {1'b0, 1'b0, parseFault, badParam | maskTooBig,
                                deviceFault, queryFault, 1'b0, opDone};
   assign evt.setVec = eventSet;
   assign evt.clear = latchRead | clearStatus;

   event_latch u_latch (
      .clk(clk),
      .rst_b(rst_b),
      .ce(ce),
      .evt(evt)
   );

   // ==========================================
   // Summary decoding
   // Rising edge of any enabled latch bit, taken from the stored latch so it
   // catches bits that rose in the previous cycle; a mask write alone is no rise
   wire logic [7:0] enabledNow = evt.value & eventMask_ff;
   wire logic [7:0] enabledPrev = prevLatch_ff & eventMask_ff;
   wire logic enabledRise = |(enabledNow & ~enabledPrev);
   wire logic [7:0] statusCore = {1'b0, 1'b0, eventSummary_ff, msgWaiting_ff, 4'h0};
   wire logic masterSummary = |(statusCore & serviceMask_ff & SRQ_GATED_MASK);
   wire logic masterRise = masterSummary & ~masterPrev_ff;
   wire logic panelSrq = panelRequest & remoteUnlocked;
   wire logic clearMsg = terminatorSent | (clearStatus & clearIsFirst);
   wire logic summaryClear = latchRead | clearStatus;

   wire logic nxt_eventSummary = enabledRise | (eventSummary_ff & ~summaryClear);
   wire logic nxt_msgWaiting = responseQueued | (msgWaiting_ff & ~clearMsg);
   wire logic nxt_serviceReq = masterRise | panelSrq | (serviceReq_ff & ~serialPoll);

   wire logic [7:0] queryByte = statusCore | ({7'h00, masterSummary} << SB_SERVICE);
   wire logic [7:0] pollByte = statusCore | ({7'h00, serviceReq_ff} << SB_SERVICE);
   wire logic [7:0] nxt_serviceMask = deviceClear ? MASK_RESET :
                                      serviceMaskWrite ? serviceMaskValue : serviceMask_ff;

   // ==========================================
   // Registers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         eventMask_ff <= MASK_RESET;
         serviceMask_ff <= MASK_RESET;
      end else if (ce) begin
         if (maskAccept) begin
            eventMask_ff <= eventMaskValue[7:0];
         end
         serviceMask_ff <= nxt_serviceMask;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         eventSummary_ff <= 1'b0;
         msgWaiting_ff <= 1'b0;
         serviceReq_ff <= 1'b0;
         masterPrev_ff <= 1'b0;
         prevLatch_ff <= BYTE_ZERO;
      end else if (ce) begin
         eventSummary_ff <= nxt_eventSummary;
         msgWaiting_ff <= nxt_msgWaiting;
         serviceReq_ff <= nxt_serviceReq;
         masterPrev_ff <= masterSummary;
         prevLatch_ff <= evt.value;
      end
   end

   // Read data are captured so the host sees a stable value after the pulse
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         latchData_ff <= BYTE_ZERO;
         statusQueryData_ff <= BYTE_ZERO;
         pollData_ff <= BYTE_ZERO;
      end else if (ce) begin
         if (latchRead) begin
            latchData_ff <= evt.value;
         end
         if (statusQuery) begin
            statusQueryData_ff <= queryByte;
         end
         if (serialPoll) begin
            pollData_ff <= pollByte;
         end
      end
   end

   assign latchData = latchData_ff;
   assign eventMaskData = eventMask_ff;
   // Bit 6 of the service mask has no meaning and reads as zero
   assign serviceMaskData = serviceMask_ff & SRQ_GATED_MASK;
   assign statusQueryData = statusQueryData_ff;
   assign pollData = pollData_ff;
   // Open drain: the line only ever sinks, so the level driven is always low
   assign srqOut = 1'b0;
   assign srqEn_b = ~serviceReq_ff;

   // ==========================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_latch_sticky: assert property (ce && evt.value[EV_QUERY_ERR] && !latchRead && !clearStatus
      |=> evt.value[EV_QUERY_ERR]) else $error("latch bit dropped");
   a_set_wins: assert property (ce && badParam && latchRead
      |=> evt.value[EV_BAD_PARAM]) else $error("event lost on clear");
   a_unused_zero: assert property (evt.value[EV_UNUSED_A] == 1'b0
      && evt.value[EV_UNUSED_B] == 1'b0) else $error("unused bit set");
   a_summary_rise: assert property (ce && parseFault && eventMask_ff[EV_PARSE_ERR]
      && !evt.value[EV_PARSE_ERR] && !latchRead && !clearStatus && !eventMaskWrite
      ##1 ce && !latchRead && !clearStatus |=> eventSummary_ff)
      else $error("summary not set");
   a_summary_clear: assert property (ce && latchRead && !enabledRise |=> !eventSummary_ff)
      else $error("summary not cleared");
   a_msg_wait: assert property (ce && responseQueued |=> msgWaiting_ff)
      else $error("message waiting not set");
   a_msg_keep: assert property (ce && clearStatus && !clearIsFirst && !terminatorSent
      && msgWaiting_ff |=> msgWaiting_ff) else $error("message waiting cleared");
   a_master_sum: assert property (masterSummary == |({eventSummary_ff, msgWaiting_ff}
      & serviceMask_ff[SB_EVENT_SUMMARY:SB_MSG_WAITING])) else $error("bad summary");
   a_poll_clear: assert property (ce && serialPoll && !masterRise && !panelSrq
      |=> !serviceReq_ff && pollData[SB_SERVICE] == $past(serviceReq_ff))
      else $error("poll handling wrong");
   a_srq_line: assert property (srqEn_b == !serviceReq_ff && srqOut == 1'b0)
      else $error("srq line wrong");
   a_query_still: assert property (ce && statusQuery && !responseQueued && !clearMsg
      && !enabledRise && !summaryClear |=> statusCore == $past(statusCore)
      && statusQueryData[SB_SERVICE] == $past(masterSummary))
      else $error("query altered status");
   a_mask_reject: assert property (ce && maskTooBig |=> eventMask_ff == $past(eventMask_ff)
      && evt.value[EV_BAD_PARAM]) else $error("mask reject failed");
   a_dev_clear: assert property (ce && deviceClear |=> serviceMask_ff == MASK_RESET)
      else $error("service mask not reset");
   a_panel_srq: assert property (ce && panelRequest && remoteUnlocked |=> serviceReq_ff)
      else $error("panel request lost");

   // ==========================================
   // Clock enable: a low enable must freeze every register

   a_ce_masks: assert property (!ce |=> $stable(eventMask_ff) && $stable(serviceMask_ff))
      else $error("mask changed while disabled");

   a_ce_status: assert property (!ce |=> $stable(eventSummary_ff) && $stable(msgWaiting_ff)
      && $stable(serviceReq_ff)) else $error("status changed while disabled");

   a_ce_latch: assert property (!ce |=> $stable(evt.value))
      else $error("latch changed while disabled");

   a_ce_data: assert property (!ce |=> $stable(latchData) && $stable(statusQueryData)
      && $stable(pollData)) else $error("read data changed while disabled");

   // ==========================================
   // Event sources and latch access

   a_opdone_set: assert property (ce && opDone |=> evt.value[EV_OP_DONE])
      else $error("operation done not latched");

   a_query_set: assert property (ce && queryFault |=> evt.value[EV_QUERY_ERR])
      else $error("query error not latched");

   a_device_set: assert property (ce && deviceFault |=> evt.value[EV_DEVICE_ERR])
      else $error("device error not latched");

   a_param_set: assert property (ce && badParam |=> evt.value[EV_BAD_PARAM])
      else $error("bad parameter not latched");

   a_parse_set: assert property (ce && parseFault |=> evt.value[EV_PARSE_ERR])
      else $error("parse error not latched");

   a_latch_clear: assert property (ce && (latchRead || clearStatus) && !opDone
      && !queryFault && !deviceFault && !badParam && !parseFault && !maskTooBig
      |=> evt.value == BYTE_ZERO) else $error("latch not cleared");

   a_latch_capture: assert property (ce && latchRead |=> latchData == $past(evt.value))
      else $error("latch read data wrong");

   a_summary_hold: assert property (ce && eventSummary_ff && !summaryClear
      |=> eventSummary_ff) else $error("summary dropped");

   // ==========================================
   // Mask registers

   a_mask_accept: assert property (ce && eventMaskWrite && eventMaskValue <= EVENT_MASK_MAX
      |=> eventMask_ff == $past(eventMaskValue[7:0])) else $error("mask not written");

   a_smask_write: assert property (ce && serviceMaskWrite && !deviceClear
      |=> serviceMask_ff == $past(serviceMaskValue)) else $error("service mask lost");

   a_smask_read: assert property (serviceMaskData[SB_SERVICE] == 1'b0)
      else $error("service mask bit 6 set");

   a_sum_masked: assert property (serviceMask_ff[SB_EVENT_SUMMARY:SB_MSG_WAITING] == 2'b00
      |-> !masterSummary) else $error("summary without enable");

   // ==========================================
   // Message waiting and service request

   a_msg_clear: assert property (ce && terminatorSent && !responseQueued |=> !msgWaiting_ff)
      else $error("message waiting not cleared");

   a_msg_first: assert property (ce && clearStatus && clearIsFirst && !responseQueued
      |=> !msgWaiting_ff) else $error("first clear kept message");

   a_req_rise: assert property (ce && masterRise |=> serviceReq_ff)
      else $error("request not raised");

   a_req_hold: assert property (ce && serviceReq_ff && !serialPoll |=> serviceReq_ff)
      else $error("request dropped without poll");

   a_panel_locked: assert property (ce && panelRequest && !remoteUnlocked && !masterRise
      && !serviceReq_ff |=> !serviceReq_ff) else $error("locked panel raised request");

   // ==========================================
   // Read bytes

   a_unused_bytes: assert property (ce && (statusQuery || serialPoll)
      |=> statusQueryData[3:0] == 4'h0 && statusQueryData[7] == 1'b0
      && pollData[3:0] == 4'h0 && pollData[7] == 1'b0) else $error("unused bit read");

   a_poll_msg: assert property (ce && serialPoll
      |=> pollData[SB_MSG_WAITING] == $past(msgWaiting_ff))
      else $error("poll message bit wrong");
endmodule // status_reporting_service_request
`default_nettype wire

// >>> tb/host_poll_model.sv
// Host side model: SRQ line pull-up and a serial poll engine.
// Assumes the device drives SRQ open drain, enable low while driving.
`timescale 1ns/1ps
`default_nettype none
module host_poll_model (
   // Clock
   input wire logic clk,
   // Bus line
   input wire logic srqOut,
   input wire logic srqEn_b,
   output logic srqLine,
   // Poll control
   input wire logic autoPoll,
   output logic hostPoll
);
   // =====================================
   // Released line floats high through the pull-up
   assign srqLine = srqEn_b ? 1'b1 : srqOut;
   initial hostPoll = 1'b0;
   // One-cycle poll, so a line release one cycle late gives no second poll
   always @(negedge clk) begin
      hostPoll <= autoPoll && !srqLine && !hostPoll;
   end
endmodule // host_poll_model
`default_nettype wire

// >>> tb/status_reporting_service_request_tb_top.sv
// Bench: pulses parser events and register commands, checks read data.
// Assumes the host model owns the SRQ pull-up and automatic polls.
`timescale 1ns/1ps
`default_nettype none
module status_reporting_service_request_tb_top
   import srq_pkg::*;
;
   logic clk = 1'b0, rst_b = 1'b0, clearIsFirst = 1'b0, remoteUnlocked = 1'b0;
   logic autoPoll = 1'b0, ce = 1'b1, srqOut, srqEn_b, srqLine, hostPoll;
   logic [14:0] cmd = 15'h0000;
   logic [15:0] eventMaskValue = 16'h0000;
   logic [7:0] serviceMaskValue = 8'h00, latchData, eventMaskData, serviceMaskData;
   logic [7:0] statusQueryData, pollData;
   int errors = 0, checks_done = 0, cycles = 0;
   int unsigned evBit [5] = '{EV_OP_DONE, EV_QUERY_ERR, EV_DEVICE_ERR, EV_BAD_PARAM, EV_PARSE_ERR};
   localparam int LIMIT = 3000;
   localparam logic [14:0] OPD = 15'h0001, BP = 15'h0008, RD = 15'h0020, CLR = 15'h0040;
   localparam logic [14:0] EMW = 15'h0080, SMW = 15'h0100, DCL = 15'h0200, SQ = 15'h0400;
   localparam logic [14:0] SP = 15'h0800, RQ = 15'h1000, TS = 15'h2000, PNL = 15'h4000;
   // =====================================
   // Clock, timeout, design and host
   initial begin
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         errors = errors + 1;
         give_verdict();
      end
   end
   status_reporting_service_request dut (
      .clk(clk), .rst_b(rst_b), .ce(ce), .opDone(cmd[0]), .queryFault(cmd[1]),
      .deviceFault(cmd[2]), .badParam(cmd[3]), .parseFault(cmd[4]), .latchRead(cmd[5]),
      .clearStatus(cmd[6]), .clearIsFirst(clearIsFirst), .eventMaskWrite(cmd[7]),
      .eventMaskValue(eventMaskValue), .serviceMaskWrite(cmd[8]),
      .serviceMaskValue(serviceMaskValue), .deviceClear(cmd[9]), .statusQuery(cmd[10]),
      .serialPoll(cmd[11] | hostPoll), .responseQueued(cmd[12]), .terminatorSent(cmd[13]),
      .panelRequest(cmd[14]), .remoteUnlocked(remoteUnlocked), .latchData(latchData),
      .eventMaskData(eventMaskData), .serviceMaskData(serviceMaskData),
      .statusQueryData(statusQueryData), .pollData(pollData), .srqOut(srqOut),
      .srqEn_b(srqEn_b));
   host_poll_model host (.clk(clk), .srqOut(srqOut), .srqEn_b(srqEn_b), .srqLine(srqLine),
      .autoPoll(autoPoll), .hostPoll(hostPoll));
   // =====================================
   // Tasks; a pulse ends with an idle cycle so no signal changes twice in a step
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic pulse(input logic [14:0] m);
      cmd = m;
      @(negedge clk);
      cmd = 15'h0000;
      @(negedge clk);
   endtask
   task automatic ask(input logic [14:0] m, input logic [7:0] exp);
      pulse(m);
      chk(m[5] ? "latch" : m[10] ? "status query" : "serial poll", exp,
         m[5] ? latchData : m[10] ? statusQueryData : pollData);
   endtask
   task automatic wrMask(input logic [15:0] ev, input logic [7:0] sv);
      eventMaskValue = ev;
      serviceMaskValue = sv;
      pulse(EMW | SMW);
   endtask
   task automatic waitSrq();
      for (int i = 0; i < 8 && srqLine !== 1'b0; i++) @(negedge clk);
      chk("srq line", 8'h00, {7'h00, srqLine});
   endtask
   task automatic give_verdict();
      $display("checks_done=%0d errors=%0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // =====================================
   // Sequence
   initial begin
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      chk("service mask", MASK_RESET, serviceMaskData);
      ask(RD, EVENT_LATCH_RESET);
      ask(RD, 8'h00);
      for (int i = 0; i < 5; i++) begin
         pulse(15'h0001 << i);
         ask(RD, 8'h01 << evBit[i]);
      end
      pulse(OPD);
      pulse(BP);
      ask(RD, 8'h11);
      wrMask(16'h0100, 8'h00);
      chk("event mask", 8'h00, eventMaskData);
      ask(RD, 8'h10);
      wrMask(16'h00ff, 8'h20);
      chk("event mask", 8'hff, eventMaskData);
      wrMask(16'h0001, 8'h20);
      pulse(BP);
      ask(SQ, 8'h00);
      pulse(OPD);
      ask(SQ, 8'h60);
      waitSrq();
      ask(SQ, 8'h60);
      ask(SP, 8'h60);
      chk("srq enable", 8'h01, {7'h00, srqEn_b});
      ask(SP, 8'h20);
      ask(RD, 8'h11);
      ask(SQ, 8'h00);
      wrMask(16'h0001, 8'h10);
      pulse(RQ);
      ask(SQ, 8'h50);
      waitSrq();
      autoPoll = 1'b1;
      for (int i = 0; i < 8 && srqLine !== 1'b1; i++) @(negedge clk);
      autoPoll = 1'b0;
      chk("serial poll", 8'h50, pollData);
      pulse(TS);
      ask(SQ, 8'h00);
      wrMask(16'h0001, 8'h00);
      pulse(RQ | OPD);
      pulse(CLR);
      ask(SQ, 8'h10);
      clearIsFirst = 1'b1;
      pulse(CLR);
      ask(SQ, 8'h00);
      ask(OPD | RD, 8'h00);
      ask(RD, 8'h01);
      pulse(RQ | TS);
      ask(SQ, 8'h10);
      pulse(TS);
      pulse(PNL);
      chk("srq line", 8'h01, {7'h00, srqLine});
      remoteUnlocked = 1'b1;
      pulse(PNL);
      waitSrq();
      ask(SP, 8'h40);
      ce = 1'b0;
      pulse(OPD | RQ);
      ce = 1'b1;
      ask(SQ, 8'h00);
      ask(RD, 8'h00);
      wrMask(16'h0020, 8'h20);
      pulse(15'h0010);
      ask(SQ, 8'h60);
      ask(RD, 8'h20);
      ask(SP, 8'h40);
      wrMask(16'h0000, 8'hff);
      chk("service mask", 8'hbe, serviceMaskData);
      pulse(DCL | SMW);
      chk("service mask", MASK_RESET, serviceMaskData);
      give_verdict();
   end
endmodule // status_reporting_service_request_tb_top
`default_nettype wire
